/* rtl/dma_handshake.sv */
/*
 * DMA request/acknowledge handshake of the codec host port, with the
 * sample down-counter and the host interrupt.
 * Assumes host pins are asynchronous and are synchronised here; sample
 * supply and consumption arrive from core logic on i_core_clk.
 */
// Notes on behaviour
// (R1) DMA needs enable set, programmed-I/O clear
// (R2) Transfer only while acknowledge is low
// (R3) Address and chip select ignored in DMA
// (R4) Request holds until acknowledged cycle happens
// (R5) Request drops on last strobe of sample
// (R6) Enable clear stops channel, finishes current sample
// (R7) Host finishes final sample after enable clear
// (R8) Single-channel mode uses playback pins only
// (R9) Single-channel: capture request low, ack ignored
// (R10) Both enables in single mode means playback; the code runs capture instead while the playback buffer is full
// (R11) Host quiesces before switching direction
// (R12) Direction follows enables, no mode change
// (R13) Dual mode runs both pairs concurrently
// (R14) Sixteen-bit base count of samples
// (R15) Upper byte write loads current counter
// (R16) Base bytes read back, counter hidden
// (R17) Counter decrements once per sample
// (R18) Interrupt on counter underflow
// (R19) Flag mirrors state; pin gated by enable
// (R20) Byte order set by endian selection
// (R21) Left channel bytes before right
// (R22) Bytes per sample from data format
`timescale 1ns/100ps
`default_nettype none
module dma_handshake (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Configuration bits
    input wire logic i_playback_enable,
    input wire logic i_capture_enable,
    input wire logic i_playback_programmed_io,
    input wire logic i_capture_programmed_io,
    input wire logic i_single_channel_select,
    input wire logic i_irq_gate,
    input wire logic [1:0] i_format,
    input wire logic i_big_endian,
    // Base count writes and interrupt clear
    input wire logic i_base_lo_wr,
    input wire logic i_base_hi_wr,
    input wire logic [7:0] i_base_wdata,
    input wire logic i_irq_clear,
    // Host pins
    input wire logic i_capture_ack_n,
    input wire logic i_playback_ack_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_cs_n,
    input wire logic [1:0] i_port_address,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_capture_request,
    output logic o_playback_request,
    output logic o_host_int,
    // Sample sides
    input wire logic i_cap_word_valid,
    input wire logic [31:0] i_cap_word,
    output logic o_cap_word_ready,
    output logic o_play_byte_valid,
    output logic [7:0] o_play_byte,
    output logic o_play_byte_last,
    input wire logic i_play_byte_ready,
    // Status
    output logic [7:0] o_base_lo,
    output logic [7:0] o_base_hi,
    output logic o_int_flag
);
    import dma_hs_pkg::*;

    typedef enum logic [2:0] {
        CH_IDLE = 3'b001,
        CH_PLAY = 3'b010,
        CH_CAP = 3'b100
    } dir_t;

    logic [SYNC_STAGES-1:0] ack_p_s;
    logic [SYNC_STAGES-1:0] ack_c_s;
    logic [SYNC_STAGES-1:0] rd_s;
    logic [SYNC_STAGES-1:0] wr_s;
    logic rd_q;
    logic wr_q;
    logic [7:0] data_r;
    dir_t pdir_r;
    dir_t pdir_nxt;
    logic creq_r;
    logic cactive_r;
    logic [2:0] pbytes_r;
    logic [2:0] cbytes_r;
    logic [2:0] sample_len;
    logic [31:0] cap_hold_r;
    logic cap_have_r;
    logic play_dma_ok;
    logic cap_dma_ok;
    logic ack_p;
    logic ack_c;
    logic rd_fall;
    logic wr_fall;
    logic wr_rise;
    logic p_strobe_fall;
    logic c_strobe_fall;
    logic sample_done;
    logic [15:0] cur_cnt_r;
    logic int_state_r;
    logic [7:0] base_lo_r;
    logic [7:0] base_hi_r;
    logic [1:0] cap_byte_idx;
    logic [7:0] cap_byte;
    logic [7:0] data_s1_r;
    logic [7:0] data_s2_r;
    logic [7:0] wdata_hold_r;
    logic last_pend_r;
    dma_hs_if buf_in ();
    dma_hs_if buf_out ();

    // Host pins are asynchronous, two flops before use
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            ack_p_s <= '1;
            ack_c_s <= '1;
            rd_s <= '1;
            wr_s <= '1;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
        end else begin
            ack_p_s <= {ack_p_s[0], i_playback_ack_n};
            ack_c_s <= {ack_c_s[0], i_capture_ack_n};
            rd_s <= {rd_s[0], i_rd_n};
            wr_s <= {wr_s[0], i_wr_n};
            rd_q <= rd_s[1];
            wr_q <= wr_s[1];
        end
    end

    // Address and chip select carry no meaning in a DMA cycle
    logic unused_pins;
    assign unused_pins = i_cs_n ^ (^i_port_address); // R3

    assign rd_fall = rd_q && !rd_s[1];
    assign wr_fall = wr_q && !wr_s[1];
    assign wr_rise = !wr_q && wr_s[1];
    assign ack_p = !ack_p_s[1];
    assign ack_c = !ack_c_s[1] && !i_single_channel_select; // R9

    // Channel permissions
    assign play_dma_ok = i_playback_enable && !i_playback_programmed_io; // R1 R12
    assign cap_dma_ok = i_capture_enable && !i_capture_programmed_io; // R1

    // Bytes per sample from the format
    always_comb begin
        unique case (i_format)
            FMT_8_MONO: sample_len = 3'h1; // R22
            FMT_8_STEREO: sample_len = 3'h2; // R22
            FMT_16_MONO: sample_len = 3'h2; // R22
            FMT_16_STEREO: sample_len = 3'h4; // R22
        endcase
    end

    // Shared playback pair direction; playback wins when both enabled and the playback buffer has room
    always_comb begin
        pdir_nxt = pdir_r;
        if (pdir_r == CH_IDLE) begin
            if (play_dma_ok && buf_in.ready) begin
                pdir_nxt = CH_PLAY; // R10
            end else if (i_single_channel_select && cap_dma_ok
                         && cap_have_r) begin
                pdir_nxt = CH_CAP; // R8
            end
        end else if (p_strobe_fall && pbytes_r + 3'h1 == sample_len) begin
            pdir_nxt = CH_IDLE; // R5
        end
    end

    // Playback pair state; request stays until a whole sample moves
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pdir_r <= CH_IDLE;
            pbytes_r <= BYTE_CNT_RST;
        end else begin
            pdir_r <= pdir_nxt; // R4
            if (pdir_nxt == CH_IDLE) begin
                pbytes_r <= BYTE_CNT_RST;
            end else if (p_strobe_fall) begin
                pbytes_r <= 3'(pbytes_r + 3'h1); // R17
            end
        end
    end

    assign p_strobe_fall = ack_p && ((pdir_r == CH_PLAY && wr_fall) ||
                           (pdir_r == CH_CAP && rd_fall)); // R2
    assign o_playback_request = (pdir_r != CH_IDLE); // R4

    // Dual-mode capture pair; an in-flight sample is always finished
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            creq_r <= 1'b0;
            cactive_r <= 1'b0;
            cbytes_r <= BYTE_CNT_RST;
        end else begin
            if (!creq_r) begin
                creq_r <= !i_single_channel_select && cap_dma_ok
                          && cap_have_r; // R13
                cbytes_r <= BYTE_CNT_RST;
            end else if (c_strobe_fall) begin
                cactive_r <= 1'b1;
                cbytes_r <= 3'(cbytes_r + 3'h1);
                if (cbytes_r + 3'h1 == sample_len) begin
                    creq_r <= 1'b0; // R5
                    cactive_r <= 1'b0; // R6
                end
            end
        end
    end

    assign c_strobe_fall = creq_r && ack_c && rd_fall; // R2
    assign o_capture_request = creq_r && !i_single_channel_select; // R9

    // Capture word latched for a whole sample, released at its end
    assign sample_done = (c_strobe_fall && cbytes_r + 3'h1 == sample_len)
        || (p_strobe_fall && pbytes_r + 3'h1 == sample_len); // R17
    assign o_cap_word_ready = !cap_have_r;
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cap_have_r <= 1'b0;
            cap_hold_r <= '0;
        end else if (!cap_have_r && i_cap_word_valid) begin
            cap_have_r <= 1'b1;
            cap_hold_r <= i_cap_word;
        end else if (cap_have_r && ((c_strobe_fall &&
                     cbytes_r + 3'h1 == sample_len) || (pdir_r == CH_CAP
                     && p_strobe_fall && pbytes_r + 3'h1 == sample_len)))
        begin
            cap_have_r <= 1'b0;
        end
    end

    // Left before right; endian swaps bytes within a 16-bit word
    assign cap_byte_idx = (pdir_r == CH_CAP) ? pbytes_r[1:0] :
                          cbytes_r[1:0]; // R21
    always_comb begin
        if (i_format[1]) begin
            cap_byte = cap_hold_r[{cap_byte_idx[1],
                                   cap_byte_idx[0] ^ i_big_endian, 3'h0}
                                  +: 8]; // R20
        end else begin
            cap_byte = cap_hold_r[{cap_byte_idx, 3'h0} +: 8];
        end
    end

    // Read data registered; drive bus while the capture read is low
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            data_r <= 8'h00;
            o_data_oe <= 1'b0;
        end else begin
            // Frozen while the synchronised read is low, so it stands
            if (rd_s[1]) begin
                data_r <= cap_byte;
            end
            o_data_oe <= !rd_s[1] && ((ack_p && pdir_r == CH_CAP) ||
                         (ack_c && creq_r)); // R2
        end
    end
    assign o_data = data_r;

    // Data pins synchronised in step with the write strobe
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            data_s1_r <= 8'h00;
            data_s2_r <= 8'h00;
            wdata_hold_r <= 8'h00;
        end else begin
            data_s1_r <= i_data;
            data_s2_r <= data_s1_r;
            if (!wr_s[1]) begin
                wdata_hold_r <= data_s2_r; // last value seen while low
            end
        end
    end

    // Last byte of a sample is marked; its rise may come after the drop
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            last_pend_r <= 1'b0;
        end else if (p_strobe_fall && pdir_r == CH_PLAY
                     && pbytes_r + 3'h1 == sample_len) begin
            last_pend_r <= 1'b1; // R5
        end else if (wr_rise && ack_p) begin
            last_pend_r <= 1'b0;
        end
    end

    // Playback bytes latched on write rise; buffer absorbs receiver stalls
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            buf_in.valid <= 1'b0;
            buf_in.data <= 9'h000;
        end else begin
            if (buf_in.ready) begin
                buf_in.valid <= 1'b0;
            end
            if (wr_rise && ack_p && (pdir_r == CH_PLAY || last_pend_r)) begin
                buf_in.valid <= 1'b1;
                buf_in.data <= {last_pend_r, wdata_hold_r}; // R20
            end
        end
    end

    dma_skid_buf u_buf (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .s_in(buf_in),
        .s_out(buf_out)
    );

    assign o_play_byte_valid = buf_out.valid;
    assign o_play_byte = buf_out.data[7:0];
    assign o_play_byte_last = buf_out.data[8];
    assign buf_out.ready = i_play_byte_ready;

    // Base count bytes; upper write loads the current counter
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            base_lo_r <= BASE_BYTE_RST;
            base_hi_r <= BASE_BYTE_RST;
        end else begin
            if (i_base_lo_wr) begin
                base_lo_r <= i_base_wdata; // R14
            end
            if (i_base_hi_wr) begin
                base_hi_r <= i_base_wdata; // R14
            end
        end
    end
    assign o_base_lo = base_lo_r; // R16
    assign o_base_hi = base_hi_r; // R16

    // Sample counter and underflow interrupt; the event beats the clear
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cur_cnt_r <= COUNT_RST;
            int_state_r <= 1'b0;
        end else begin
            if (i_base_hi_wr) begin
                cur_cnt_r <= {i_base_wdata, base_lo_r}; // R15
            end else if (sample_done) begin
                cur_cnt_r <= 16'(cur_cnt_r - 16'h0001); // R17
            end
            if (sample_done && cur_cnt_r == 16'h0000) begin
                int_state_r <= 1'b1; // R18
            end else if (i_irq_clear) begin
                int_state_r <= 1'b0;
            end
        end
    end

    assign o_int_flag = int_state_r; // R19
    assign o_host_int = int_state_r && i_irq_gate; // R19
endmodule
`default_nettype wire

/* rtl/dma_hs_if.sv */
/*
 * Byte stream carrier between the handshake core and its skid buffer.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface dma_hs_if;
    logic valid;
    logic ready;
    logic [8:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* rtl/dma_hs_pkg.sv */
/*
 * Shared constants for the codec DMA handshake block.
 * Assumes a single 40 MHz core clock and synchronous active-high reset.
 */
package dma_hs_pkg;
    // Data format codes
    localparam logic [1:0] FMT_8_MONO = 2'h0;
    localparam logic [1:0] FMT_8_STEREO = 2'h1;
    localparam logic [1:0] FMT_16_MONO = 2'h2;
    localparam logic [1:0] FMT_16_STEREO = 2'h3;
    // Widths and reset values
    localparam int COUNT_W = 16;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [7:0] BASE_BYTE_RST = 8'h00;
    localparam logic [2:0] BYTE_CNT_RST = 3'h0;
    localparam int SYNC_STAGES = 2;
    localparam int BUF_DEPTH = 2;
endpackage

/* rtl/dma_skid_buf.sv */
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes the upstream holds data stable while valid and not ready.
 */
`timescale 1ns/100ps
`default_nettype none
module dma_skid_buf (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Streams
    dma_hs_if.snk s_in,
    dma_hs_if.src s_out
);
    import dma_hs_pkg::*;

    logic [8:0] mem_r [BUF_DEPTH];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] cnt_r;
    logic do_wr;
    logic do_rd;

    // Full and empty come straight from the occupancy count
    assign s_in.ready = (cnt_r != 2'h2);
    assign s_out.valid = (cnt_r != 2'h0);
    assign s_out.data = mem_r[rd_ptr_r];
    assign do_wr = s_in.valid && s_in.ready;
    assign do_rd = s_out.valid && s_out.ready;

    // Storage
    always_ff @(posedge i_core_clk) begin
        if (do_wr) begin
            mem_r[wr_ptr_r] <= s_in.data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (do_wr) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (do_rd) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            cnt_r <= 2'(cnt_r + {1'b0, do_wr} - {1'b0, do_rd});
        end
    end
endmodule
`default_nettype wire

/* verif/dma_handshake_test.sv */
/*
 * Self-checking bench for dma_handshake with a host DMA model.
 * Assumes the checker bind and the host model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module dma_handshake_test;
    import dma_hs_pkg::*;
    logic i_core_clk = 0, i_reset = 1, i_playback_enable = 0;
    logic i_capture_enable = 0, i_playback_programmed_io = 0;
    logic i_capture_programmed_io = 0, i_single_channel_select = 0;
    logic i_irq_gate = 0, i_big_endian = 0, i_base_lo_wr = 0;
    logic i_base_hi_wr = 0, i_irq_clear = 0, i_cap_word_valid = 0;
    logic i_play_byte_ready = 1, i_cs_n = 1;
    logic i_capture_ack_n, i_playback_ack_n, i_rd_n, i_wr_n, o_data_oe;
    logic o_capture_request, o_playback_request, o_host_int, o_int_flag;
    logic o_cap_word_ready, o_play_byte_valid, o_play_byte_last;
    logic [1:0] i_format = 0, i_port_address = 0;
    logic [7:0] i_base_wdata = 0, i_data, o_data, o_play_byte;
    logic [7:0] o_base_lo, o_base_hi, pq[$];
    logic lq[$];
    logic [31:0] i_cap_word = 32'h44332211;
    int num_errors = 0, num_checks = 0;
    // Format, endian, single, mode (0 cap 1 play 2 both), bytes
    localparam logic [8:0] rows [10] = '{9'h001, 9'h0CA, 9'h102, 9'h14A,
        9'h1D4, 9'h1A4, 9'h1B4, 9'h132, 9'h0AA, 9'h021};
    wire logic play_rd = i_single_channel_select && !i_playback_enable;
    dma_handshake uut (.i_core_clk, .i_reset, .i_playback_enable,
        .i_capture_enable, .i_playback_programmed_io,
        .i_capture_programmed_io, .i_single_channel_select, .i_irq_gate,
        .i_format, .i_big_endian, .i_base_lo_wr, .i_base_hi_wr,
        .i_base_wdata, .i_irq_clear, .i_capture_ack_n, .i_playback_ack_n,
        .i_rd_n, .i_wr_n, .i_cs_n, .i_port_address, .i_data, .o_data,
        .o_data_oe, .o_capture_request, .o_playback_request, .o_host_int,
        .i_cap_word_valid, .i_cap_word, .o_cap_word_ready,
        .o_play_byte_valid, .o_play_byte, .o_play_byte_last,
        .i_play_byte_ready, .o_base_lo, .o_base_hi, .o_int_flag);
    host_dma_model host (.i_core_clk, .i_cap_req(o_capture_request),
        .i_play_req(o_playback_request), .i_play_rd(play_rd),
        .i_rdata(o_data), .o_cap_ack_n(i_capture_ack_n),
        .o_play_ack_n(i_playback_ack_n), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n),
        .o_wdata(i_data));
    initial forever #12.5 i_core_clk = ~i_core_clk;
    // Noise on ignored pins; sink stalls one cycle in four
    always @(posedge i_core_clk) begin
        i_cs_n <= ~i_cs_n;
        i_port_address <= i_port_address + 2'h1;
        i_play_byte_ready <= i_port_address != 2'h3;
        if (o_play_byte_valid === 1'b1 && i_play_byte_ready) begin
            pq.push_back(o_play_byte);
            lq.push_back(o_play_byte_last);
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cycles(input int c);
        repeat (c) @(posedge i_core_clk);
    endtask
    task automatic wait_samples(input int s);
        for (int t = 0; t < 3000 && host.samples < s; t++) cycles(1);
    endtask
    // Clear both enables, let the host finish what is pending
    task automatic quiesce();
        i_capture_enable <= 1'b0;
        i_playback_enable <= 1'b0;
        i_cap_word_valid <= 1'b0;
        cycles(200);
    endtask
    task automatic run_row(input logic [8:0] r);
        logic cx, px;
        logic [7:0] w0;
        int n, ix;
        n = r[2:0];
        cx = r[4:3] != 2'h1 && !(r[5] && r[4:3] == 2'h2);
        px = r[4:3] != 2'h0;
        {i_format, i_big_endian, i_single_channel_select} <= r[8:5];
        cycles(1);
        pq.delete();
        lq.delete();
        host.rq.delete();
        w0 = host.wd;
        i_capture_enable <= r[4:3] != 2'h1;
        i_playback_enable <= px;
        i_cap_word_valid <= r[4:3] != 2'h1;
        for (int t = 0; t < 3000; t++) begin
            if ((!cx || host.rq.size() >= n) && (!px || pq.size() >= n)) break;
            cycles(1);
        end
        cycles(12);
        check(8'(host.last_n), 8'(n));
        if (px) check({7'h00, lq[n-1]}, 8'h01);
        quiesce();
        for (int k = 0; k < n; k++) begin
            ix = (r[6] && r[8]) ? k ^ 1 : k;
            if (cx) check(host.rq[k], i_cap_word[ix*8 +: 8]);
            if (px) check(pq[k], w0 + 8'(k));
        end
        $display("row %h done", r);
    endtask
    // Count of one: underflow after the second sample
    task automatic irq_test();
        i_format <= FMT_8_MONO;
        i_single_channel_select <= 1'b0;
        i_irq_clear <= 1'b1;
        i_base_wdata <= 8'h01;
        i_base_lo_wr <= 1'b1;
        cycles(1);
        i_irq_clear <= 1'b0;
        i_base_lo_wr <= 1'b0;
        i_base_wdata <= 8'h00;
        i_base_hi_wr <= 1'b1;
        cycles(1);
        i_base_hi_wr <= 1'b0;
        cycles(2);
        check(o_base_lo, 8'h01);
        check(o_base_hi, 8'h00);
        i_capture_enable <= 1'b1;
        i_cap_word_valid <= 1'b1;
        wait_samples(host.samples + 1);
        cycles(2);
        check({7'h00, o_int_flag}, 8'h00);
        wait_samples(host.samples + 1);
        quiesce();
        check({7'h00, o_int_flag}, 8'h01);
        check({7'h00, o_host_int}, 8'h00);
        i_irq_gate <= 1'b1;
        cycles(2);
        check({7'h00, o_host_int}, 8'h01);
        i_irq_clear <= 1'b1;
        cycles(1);
        i_irq_clear <= 1'b0;
        cycles(2);
        check({7'h00, o_int_flag}, 8'h00);
        $display("interrupt test done");
    endtask
    task automatic reset_check();
        check({6'h00, o_capture_request, o_playback_request}, 8'h00);
        check({6'h00, o_data_oe, o_host_int}, 8'h00);
    endtask
    initial begin
        cycles(2);
        i_reset <= 1'b0;
        cycles(1);
        reset_check();
        check(o_base_lo, BASE_BYTE_RST);
        $display("reset test done");
        foreach (rows[i]) run_row(rows[i]);
        irq_test();
        i_playback_enable <= 1'b1;
        cycles(1);
        i_reset <= 1'b1;
        cycles(2);
        reset_check();
        check(o_base_hi, BASE_BYTE_RST);
        $display("mid-run reset test done");
        give_verdict();
    end
    // Watchdog well past the expected run length
    initial begin
        #(90000 * 25);
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire

/* verif/dma_hs_props.sv */
/*
 * Concurrent checks on the handshake block's ports.
 * Assumes it is bound onto every dma_handshake instance.
 */
`timescale 1ns/100ps
`default_nettype none
module dma_hs_props (
    // Clock, reset and control
    input wire logic i_core_clk, i_reset, i_single_channel_select,
    input wire logic i_capture_enable, i_capture_programmed_io,
    input wire logic i_irq_gate, i_irq_clear, i_base_lo_wr, i_base_hi_wr,
    // Host strobes and data
    input wire logic i_rd_n, i_wr_n, o_data_oe,
    input wire logic [7:0] i_base_wdata, o_base_lo, o_base_hi,
    // Requests and interrupt
    input wire logic o_capture_request, o_playback_request,
    input wire logic o_host_int, o_int_flag
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    logic cap_off;
    // Capture DMA is blocked by a clear enable or programmed-I/O
    assign cap_off = !i_capture_enable || i_capture_programmed_io;
    // No strobe for eight cycles: sync delay has long run out
    sequence quiet_s;
        (i_rd_n && i_wr_n) [*8];
    endsequence
    AST_CAP_PIN_LOW: assert property (
        i_single_channel_select && $past(i_single_channel_select)
        |-> !o_capture_request) else $error("capture request in single mode");
    AST_HOST_INT_GATE: assert property (
        o_host_int == (o_int_flag && i_irq_gate)) else $error("int pin");
    AST_BASE_LO: assert property (
        i_base_lo_wr |=> o_base_lo == $past(i_base_wdata)) else $error("lo");
    AST_BASE_HI: assert property (
        i_base_hi_wr |=> o_base_hi == $past(i_base_wdata)) else $error("hi");
    AST_PLAY_HOLD: assert property (
        quiet_s ##0 o_playback_request |=> o_playback_request)
        else $error("playback request dropped unserved");
    AST_CAP_HOLD: assert property (
        quiet_s ##0 o_capture_request |=> o_capture_request)
        else $error("capture request dropped unserved");
    AST_CAP_BLOCKED: assert property (
        cap_off && $past(cap_off) && !$past(o_capture_request)
        |-> !o_capture_request) else $error("capture request while off");
    AST_OE_QUIET: assert property (
        quiet_s |-> !o_data_oe) else $error("bus driven without read");
    AST_FLAG_HOLD: assert property (
        o_int_flag && !i_irq_clear |=> o_int_flag) else $error("flag lost");
endmodule
bind dma_handshake dma_hs_props chk (.i_core_clk, .i_reset,
    .i_single_channel_select, .i_capture_enable, .i_capture_programmed_io,
    .i_irq_gate, .i_irq_clear, .i_base_lo_wr, .i_base_hi_wr, .i_rd_n,
    .i_wr_n, .o_data_oe, .i_base_wdata, .o_base_lo, .o_base_hi,
    .o_capture_request, .o_playback_request, .o_host_int, .o_int_flag);
`default_nettype wire

/* verif/host_dma_model.sv */
/*
 * Host DMA controller model: answers requests with acknowledge and
 * byte strobes. Assumes the core clock; strobes are five cycles low.
 */
`timescale 1ns/100ps
`default_nettype none
module host_dma_model (
    // Clock and device side
    input wire logic i_core_clk,
    input wire logic i_cap_req,
    input wire logic i_play_req,
    input wire logic i_play_rd,
    input wire logic [7:0] i_rdata,
    // Host pins
    output logic o_cap_ack_n,
    output logic o_play_ack_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [7:0] o_wdata
);
    logic [7:0] rq[$];
    logic [7:0] wd = 8'h00;
    logic cap, rd, drop;
    int n, last_n = 0, samples = 0;
    // Released data lines show the inverse of the current byte wd
    assign o_wdata = o_wr_n ? ~wd : wd;
    initial begin
        o_cap_ack_n = 1'b1;
        o_play_ack_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
    end
    // One request at a time, capture first; keep going while requested
    always begin
        @(posedge i_core_clk);
        if (i_cap_req === 1'b1 || i_play_req === 1'b1) begin
            cap = i_cap_req === 1'b1;
            rd = cap || i_play_rd;
            n = 0;
            o_cap_ack_n <= !cap;
            o_play_ack_n <= cap;
            drop = 1'b0;
            // One sample per grant: a request dip marks its last byte
            while (!drop) begin
                repeat (3) @(posedge i_core_clk);
                o_rd_n <= !rd;
                o_wr_n <= rd;
                repeat (5) begin
                    @(posedge i_core_clk);
                    if ((cap ? i_cap_req : i_play_req) !== 1'b1) drop = 1'b1;
                end
                if (rd) rq.push_back(i_rdata);
                o_rd_n <= 1'b1;
                o_wr_n <= 1'b1;
                n++;
                repeat (4) @(posedge i_core_clk);
                if (!rd) wd += 8'h01;
            end
            last_n = n;
            samples++;
            o_cap_ack_n <= 1'b1;
            o_play_ack_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire
